// ===== rtl/tmc_timer_mode_config.sv
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
module tmc_timer_mode_config #(
    parameter int COUNT_W = 32
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic [tmc_pkg::REG_AW-1:0] regAddr,
    input wire logic [tmc_pkg::REG_DW-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [tmc_pkg::REG_DW-1:0] regRdata,
    output logic [2:0] opMode,
    output logic subAAltPwm,
    output logic subACaptTime,
    output logic [1:0] subAMode,
    output logic subBAltPwm,
    output logic subBCaptTime,
    output logic [1:0] subBMode,
    output logic subACounting,
    output logic subBCounting
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage.

    logic [tmc_pkg::CFG_W-1:0] cfg_q;
    logic [tmc_pkg::MODE_W-1:0] modeA_q;
    logic [tmc_pkg::MODE_W-1:0] modeB_q;
    logic runA_q, frzA_q, runB_q, frzB_q;
    logic [COUNT_W-1:0] countA_q;
    logic [COUNT_W-1:0] countB_q;
    logic [tmc_pkg::REG_DW-1:0] rdata_q;

    function automatic tmc_pkg::tmc_op_t decodeOp(input logic [2:0] code);
        case (code)
            tmc_pkg::CFG_WIDE32: decodeOp = tmc_pkg::TMC_OP_WIDE32;
            tmc_pkg::CFG_ONESHOT16: decodeOp = tmc_pkg::TMC_OP_ONESHOT16;
            tmc_pkg::CFG_PERIODIC16: decodeOp = tmc_pkg::TMC_OP_PERIODIC16;
            tmc_pkg::CFG_CAPTURE16: decodeOp = tmc_pkg::TMC_OP_CAPTURE16;
            tmc_pkg::CFG_PWM16: decodeOp = tmc_pkg::TMC_OP_PWM16;
            default: decodeOp = tmc_pkg::TMC_OP_RESERVED;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.

    wire selCfg = regAddr == tmc_pkg::OFF_CFG;
    wire selModeA = regAddr == tmc_pkg::OFF_AMODE;
    wire selModeB = regAddr == tmc_pkg::OFF_BMODE;
    wire selCtl = regAddr == tmc_pkg::OFF_CTL;
    wire selCountA = regAddr == tmc_pkg::OFF_ACOUNT;
    wire selCountB = regAddr == tmc_pkg::OFF_BCOUNT;
    wire wrCfg = regWrite && selCfg;
    wire wrModeA = regWrite && selModeA;
    wire wrModeB = regWrite && selModeB;
    wire wrCtl = regWrite && selCtl;

    wire runANext = wrCtl ? regWdata[tmc_pkg::CTL_A_RUN_BIT] : runA_q;
    wire runBNext = wrCtl ? regWdata[tmc_pkg::CTL_B_RUN_BIT] : runB_q;
    wire tickA = runA_q && !frzA_q;
    wire tickB = runB_q && !frzB_q;

    logic [tmc_pkg::REG_DW-1:0] readMux;
    always_comb begin
        readMux = '0;
        if (selCfg) begin
            readMux[tmc_pkg::CFG_W-1:0] = cfg_q;
        end else if (selModeA) begin
            readMux[tmc_pkg::MODE_W-1:0] = modeA_q;
        end else if (selModeB) begin
            readMux[tmc_pkg::MODE_W-1:0] = modeB_q;
        end else if (selCtl) begin
            readMux[tmc_pkg::CTL_A_RUN_BIT] = runA_q;
            readMux[tmc_pkg::CTL_A_FRZ_BIT] = frzA_q;
            readMux[tmc_pkg::CTL_B_RUN_BIT] = runB_q;
            readMux[tmc_pkg::CTL_B_FRZ_BIT] = frzB_q;
        end else if (selCountA) begin
            readMux[COUNT_W-1:0] = countA_q;
        end else if (selCountB) begin
            readMux[COUNT_W-1:0] = countB_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers. Writes are taken as given; the block does not
    // police the halt-before-write convention, it only keeps state coherent.

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cfg_q <= tmc_pkg::CFG_RESET;
            modeA_q <= tmc_pkg::MODE_RESET;
            modeB_q <= tmc_pkg::MODE_RESET;
            runA_q <= 1'b0;
            frzA_q <= 1'b0;
            runB_q <= 1'b0;
            frzB_q <= 1'b0;
            rdata_q <= '0;
        end else if (clkEn) begin
            if (wrCfg) begin
                cfg_q <= regWdata[tmc_pkg::CFG_W-1:0];
            end
            if (wrModeA) begin
                modeA_q <= regWdata[tmc_pkg::MODE_W-1:0];
            end
            if (wrModeB) begin
                modeB_q <= regWdata[tmc_pkg::MODE_W-1:0];
            end
            if (wrCtl) begin
                runA_q <= regWdata[tmc_pkg::CTL_A_RUN_BIT];
                frzA_q <= regWdata[tmc_pkg::CTL_A_FRZ_BIT];
                runB_q <= regWdata[tmc_pkg::CTL_B_RUN_BIT];
                frzB_q <= regWdata[tmc_pkg::CTL_B_FRZ_BIT];
            end
            rdata_q <= regRead ? readMux : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Stand-in counters. They only show run, freeze and restart behaviour;
    // the real datapath with loads, matches and prescale lives elsewhere.

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            countA_q <= COUNT_W'(tmc_pkg::COUNT_RESET);
            countB_q <= COUNT_W'(tmc_pkg::COUNT_RESET);
        end else if (clkEn) begin
            if (!runANext) begin
                countA_q <= COUNT_W'(tmc_pkg::COUNT_RESET);
            end else if (tickA) begin
                countA_q <= countA_q - COUNT_W'(1);
            end
            if (!runBNext) begin
                countB_q <= COUNT_W'(tmc_pkg::COUNT_RESET);
            end else if (tickB) begin
                countB_q <= countB_q - COUNT_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoded configuration outputs.

    tmc_pkg::tmc_op_t opDecoded;
    assign opDecoded = decodeOp(cfg_q);
    assign opMode = opDecoded;
    assign subAAltPwm = modeA_q[tmc_pkg::MODE_ALT_BIT];
    assign subACaptTime = modeA_q[tmc_pkg::MODE_CAPT_BIT];
    assign subAMode = modeA_q[tmc_pkg::MODE_SEL_HI:0];
    assign subBAltPwm = modeB_q[tmc_pkg::MODE_ALT_BIT];
    assign subBCaptTime = modeB_q[tmc_pkg::MODE_CAPT_BIT];
    assign subBMode = modeB_q[tmc_pkg::MODE_SEL_HI:0];
    assign subACounting = tickA;
    assign subBCounting = tickB;
    assign regRdata = rdata_q;

endmodule

// ===== rtl/tmc_pkg.sv
package tmc_pkg;
    localparam int REG_AW = 8;
    localparam int REG_DW = 32;
    // Register byte offsets.
    localparam logic [7:0] OFF_CFG = 8'h00;
    localparam logic [7:0] OFF_AMODE = 8'h04;
    localparam logic [7:0] OFF_BMODE = 8'h08;
    localparam logic [7:0] OFF_CTL = 8'h0C;
    localparam logic [7:0] OFF_ACOUNT = 8'h48;
    localparam logic [7:0] OFF_BCOUNT = 8'h4C;
    // Field widths and positions.
    localparam int CFG_W = 3;
    localparam int MODE_W = 4;
    localparam int MODE_ALT_BIT = 3;
    localparam int MODE_CAPT_BIT = 2;
    localparam int MODE_SEL_HI = 1;
    localparam int CTL_A_RUN_BIT = 0;
    localparam int CTL_A_FRZ_BIT = 1;
    localparam int CTL_B_RUN_BIT = 8;
    localparam int CTL_B_FRZ_BIT = 9;
    // Reset values.
    localparam logic [2:0] CFG_RESET = 3'h0;
    localparam logic [3:0] MODE_RESET = 4'h0;
    localparam logic [31:0] COUNT_RESET = 32'hFFFFFFFF;
    // Global configuration codes.
    localparam logic [2:0] CFG_WIDE32 = 3'h0;
    localparam logic [2:0] CFG_ONESHOT16 = 3'h4;
    localparam logic [2:0] CFG_PERIODIC16 = 3'h5;
    localparam logic [2:0] CFG_CAPTURE16 = 3'h6;
    localparam logic [2:0] CFG_PWM16 = 3'h7;
    typedef enum logic [1:0] {
        TMC_MODE_PWMUD = 2'h0,
        TMC_MODE_ONESHOT = 2'h1,
        TMC_MODE_PERIODIC = 2'h2,
        TMC_MODE_CAPTURE = 2'h3
    } tmc_submode_t;
    typedef enum logic [2:0] {
        TMC_OP_WIDE32,
        TMC_OP_ONESHOT16,
        TMC_OP_PERIODIC16,
        TMC_OP_CAPTURE16,
        TMC_OP_PWM16,
        TMC_OP_RESERVED
    } tmc_op_t;
endpackage

// ===== sim/tmc_timer_mode_config_checker.sv
`timescale 1ns/1ps
module tmc_timer_mode_config_checker (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input logic [31:0] regRdata,
    input logic [2:0] opMode,
    input logic subAAltPwm,
    input logic subACaptTime,
    input logic [1:0] subAMode,
    input logic subBAltPwm,
    input logic subBCaptTime,
    input logic [1:0] subBMode,
    input logic subACounting
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire logic wrEn = clkEn && regWrite;
    wire logic rdEn = clkEn && regRead;
    a_cfg_code_four: assert property (wrEn && regAddr == 8'h00 && regWdata[2:0] == 3'h4 |=> opMode == 3'h1) else $error("cfg 4 decode wrong");
    a_cfg_code_rsvd: assert property (wrEn && regAddr == 8'h00 && regWdata[2:0] inside {[1:3]} |=> opMode == 3'h5) else $error("reserved cfg decode wrong");
    a_cfg_hold_value: assert property (!(wrEn && regAddr == 8'h00) |=> $stable(opMode)) else $error("cfg changed without write");
    a_amode_fields: assert property (wrEn && regAddr == 8'h04 |=> {subAAltPwm, subACaptTime, subAMode} == $past(regWdata[3:0])) else $error("A mode fields wrong");
    a_bmode_fields: assert property (wrEn && regAddr == 8'h08 |=> {subBAltPwm, subBCaptTime, subBMode} == $past(regWdata[3:0])) else $error("B mode fields wrong");
    a_cfg_rsvd_zero: assert property (rdEn && regAddr inside {8'h00, 8'h04, 8'h08} |=>
        regRdata[31:4] == 28'h0 && (regRdata[3] == 1'b0 || $past(regAddr) != 8'h00))
        else $error("reserved bits read back set");
    a_rdata_idle_zero: assert property (clkEn && !regRead |=> regRdata == 32'h0) else $error("read data not cleared");
    a_run_freeze_bits: assert property (wrEn && regAddr == 8'h0C |=> subACounting == ($past(regWdata[0]) && !$past(regWdata[1]))) else $error("A run state wrong");
endmodule
bind tmc_timer_mode_config tmc_timer_mode_config_checker tmc_timer_mode_config_checker_i (.*);

// ===== sim/tmc_timer_mode_config_test.sv
`timescale 1ns/1ps
module tmc_timer_mode_config_test;
    logic core_clk, sys_rst, clkEn, regWrite, regRead, subACounting, subBCounting;
    logic subAAltPwm, subACaptTime, subBAltPwm, subBCaptTime;
    logic [1:0] subAMode, subBMode;
    logic [2:0] opMode;
    logic [7:0] regAddr, ca;
    logic [31:0] regWdata, regRdata, d, e, rd0, rd1;
    integer seed = 58827, n_mismatch = 0, cmp_count = 0, cycles = 0, i;
    tmc_timer_mode_config tmc_timer_mode_config_i (.*);
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // The whole sequence needs well under a thousand cycles.
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            n_mismatch = n_mismatch + 1;
            wrap_up;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= v;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 v = regRdata;
    endtask
    function automatic logic [2:0] opExp(input logic [2:0] c);
        case (c)
            3'h0: opExp = 3'h0;
            3'h4: opExp = 3'h1;
            3'h5: opExp = 3'h2;
            3'h6: opExp = 3'h3;
            3'h7: opExp = 3'h4;
            default: opExp = 3'h5;
        endcase
    endfunction
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_rst = 1'b1; clkEn = 1'b1; regWrite = 1'b0; regRead = 1'b0;
        regAddr = 8'h00; regWdata = 32'h0;
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 4; i++) begin
            rd(8'(i * 4), d); chk(d, 32'h0);
        end
        rd(8'h4C, d); chk(d, 32'hFFFFFFFF);
        for (i = 0; i < 8; i++) begin
            d = $random(seed); d[2:0] = 3'(i); wr(8'h00, d);
            rd(8'h00, e); chk(e, {29'h0, d[2:0]});
            chk(32'(opMode), 32'(opExp(d[2:0])));
        end
        @(posedge core_clk); clkEn <= 1'b0; wr(8'h00, 32'h5); clkEn <= 1'b1;
        rd(8'h00, e); chk(e, 32'h7);
        $display("config test done");
        for (i = 0; i < 20; i++) begin
            d = $random(seed); e = $random(seed); wr(8'h04, d); wr(8'h08, e); #1;
            chk(32'({subAAltPwm, subACaptTime, subAMode}), 32'(d[3:0]));
            chk(32'({subBAltPwm, subBCaptTime, subBMode}), 32'(e[3:0]));
            rd(8'h04, rd0); chk(rd0, d & 32'hF);
            rd(8'h08, rd0); chk(rd0, e & 32'hF);
        end
        wr(8'h10, $random(seed)); rd(8'h10, d); chk(d, 32'h0);
        $display("mode test done");
        for (i = 0; i < 2; i++) begin
            ca = i ? 8'h4C : 8'h48;
            wr(8'h0C, 32'h1 << (8 * i)); repeat (5) @(posedge core_clk);
            wr(8'h0C, 32'h3 << (8 * i)); rd(ca, rd0); repeat (7) @(posedge core_clk);
            rd(ca, d); chk(d, rd0);
            wr(8'(4 + 4 * i), 32'hA); #1;
            chk(32'(i ? {subBAltPwm, subBCaptTime} : {subAAltPwm, subACaptTime}), 32'h2);
            chk(32'(i ? subBCounting : subACounting), 32'h0);
            wr(8'h0C, 32'h1 << (8 * i)); rd(ca, rd1);
            chk(32'(rd1 < rd0 && rd0 - rd1 < 10), 32'h1);
            wr(8'h0C, 32'h0); wr(8'h0C, 32'h1 << (8 * i)); rd(ca, rd1);
            chk(32'(rd1 > 32'hFFFFFFF0), 32'h1);
            wr(8'h0C, 32'h0);
        end
        $display("count test done");
        wrap_up;
    end
endmodule
